// file: hdl/cpu_instruction_semantics.sv
`timescale 1ns/100ps
`include "cpu_defines.svh"

module cpu_instruction_semantics
  import cpu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // program memory, data valid while prog_rd is high
  output logic [`PC_W-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [`DATA_W-1:0] prog_data,
  // data memory, read data valid while data_rd is high
  output logic [`DATA_W-1:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [`DATA_W-1:0] data_wdata,
  input wire logic [`DATA_W-1:0] data_rdata,
  // interrupt side
  input wire logic [`PC_W-1:0] vector_addr,
  input wire logic soft_int_set,
  output logic soft_pending,
  // architectural state view
  output logic [`PC_W-1:0] pc,
  output logic [`DATA_W-1:0] acc,
  output logic [`DATA_W-1:0] ptr_b,
  output logic [`DATA_W-1:0] ptr_x,
  output logic [`DATA_W-1:0] stack_ptr,
  output logic carry,
  output logic half_carry,
  output logic instr_done
);

  seq_state_e state_reg, state_next;
  logic [7:0] op_reg, op_next, imm1_reg, imm1_next, imm2_reg, imm2_next;
  logic [7:0] mem_reg, mem_next;
  logic skip_reg, skip_next, done_reg, done_next, pend_reg, clr_pend;
  logic [`PC_W-1:0] pc_reg, pc_next, iaddr_reg, iaddr_next;
  logic [`PC_W-1:0] paddr_reg, paddr_next;
  logic [7:0] acc_reg, acc_next, b_reg, b_next, x_reg, x_next;
  logic [7:0] sp_reg, sp_next;
  logic c_reg, c_next, hc_reg, hc_next;
  logic prd_reg, prd_next, drd_reg, drd_next, dwr_reg, dwr_next;
  logic [7:0] daddr_reg, daddr_next, dwdata_reg, dwdata_next;
  logic alu, auto_fn, prom_read, data_read, cin;
  logic [3:0] func;
  logic [1:0] mode;
  logic [7:0] opnd, addend, opnd_addr, bit_mask;
  logic [8:0] sum9;
  logic [4:0] half5;

  // extra instruction bytes that follow the opcode
  function automatic logic [1:0] extra_bytes(input logic [7:0] op);
    if (op[7:6] == 2'b11)
      return (op[1] == 1'b1) ? 2'd1 : 2'd0;
    else if (op[7:4] == `GRP_JMP_ABS || op[7:4] == `GRP_CALL_ABS)
      return 2'd1;
    else if (op == `OP_JMP_LONG || op == `OP_CALL_LONG || op == `OP_MD_EQ)
      return 2'd2;
    else if (op == `OP_AND_SKIP || op == `OP_LDB_IMM)
      return 2'd1;
    else
      return 2'd0;
  endfunction

  // opcode decode
  assign alu = (op_reg[7:6] == 2'b11);
  assign func = op_reg[5:2];
  assign mode = op_reg[1:0];
  assign auto_fn = (func >= `FN_LD_INC);
  assign prom_read = (op_reg == `OP_TBL_LOAD) || (op_reg == `OP_TBL_JUMP);
  assign data_read = (alu && mode != `MODE_IMM) ||
    (op_reg[7:5] == 3'b011) || (op_reg[7:4] == `GRP_DEC_SKIP) ||
    (op_reg == `OP_MD_EQ) || (op_reg == `OP_POP_A);
  assign opnd = (alu && mode == `MODE_IMM) ? imm1_reg : mem_reg;
  assign bit_mask = 8'h01 << op_reg[2:0];

  // adder shared by add, add with carry and subtract with carry
  assign cin = (func == `FN_ADC || func == `FN_SUBTRACT_WITH_CARRY) ? c_reg : 1'b0;
  assign addend = (func == `FN_SUBTRACT_WITH_CARRY) ? ~opnd : opnd;
  assign sum9 = {1'b0, acc_reg} + {1'b0, addend} + {8'h00, cin};
  assign half5 = {1'b0, acc_reg[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

  // operand address in data memory
  always_comb begin
    opnd_addr = b_reg;
    if (alu) begin
      if (auto_fn)
        opnd_addr = mode[0] ? x_reg : b_reg;
      else if (mode == `MODE_X)
        opnd_addr = x_reg;
      else if (mode == `MODE_DIR)
        opnd_addr = imm1_reg;
    end else if (op_reg[7:4] == `GRP_DEC_SKIP)
      opnd_addr = {`REG_PAGE, op_reg[3:0]};
    else if (op_reg == `OP_MD_EQ)
      opnd_addr = imm1_reg;
    else if (op_reg == `OP_POP_A)
      opnd_addr = sp_reg + 8'h01;
  end

  // sequencer and execute
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    imm1_next = imm1_reg;
    imm2_next = imm2_reg;
    mem_next = mem_reg;
    skip_next = skip_reg;
    iaddr_next = iaddr_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    x_next = x_reg;
    sp_next = sp_reg;
    c_next = c_reg;
    hc_next = hc_reg;
    prd_next = 1'b0;
    paddr_next = paddr_reg;
    drd_next = 1'b0;
    dwr_next = 1'b0;
    daddr_next = daddr_reg;
    dwdata_next = dwdata_reg;
    clr_pend = 1'b0;
    done_next = 1'b0;
    unique case (state_reg)
      ST_FETCH: begin
        paddr_next = pc_reg;
        prd_next = 1'b1;
        pc_next = pc_reg + 15'h0001;
        iaddr_next = pc_reg;
        state_next = ST_OP;
      end
      ST_OP: begin
        op_next = prog_data;
        state_next = ST_ADDR;
        if (extra_bytes(prog_data) != 2'd0) begin
          paddr_next = pc_reg;
          prd_next = 1'b1;
          pc_next = pc_reg + 15'h0001;
          state_next = ST_IMM1;
        end
      end
      ST_IMM1: begin
        imm1_next = prog_data;
        state_next = ST_ADDR;
        if (extra_bytes(op_reg) == 2'd2) begin
          paddr_next = pc_reg;
          prd_next = 1'b1;
          pc_next = pc_reg + 15'h0001;
          state_next = ST_IMM2;
        end
      end
      ST_IMM2: begin
        imm2_next = prog_data;
        state_next = ST_ADDR;
      end
      ST_ADDR: begin
        if (skip_reg) begin
          skip_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_FETCH;
        end else if (op_reg == `OP_VECTOR) begin
          paddr_next = vector_addr;
          prd_next = 1'b1;
          state_next = ST_VEC_HI;
        end else if (prom_read) begin
          paddr_next = {pc_reg[14:8], acc_reg};
          prd_next = 1'b1;
          state_next = ST_MEM;
        end else if (data_read) begin
          daddr_next = opnd_addr;
          drd_next = 1'b1;
          if (op_reg == `OP_POP_A)
            sp_next = sp_reg + 8'h01;
          state_next = ST_MEM;
        end else
          state_next = ST_EXEC;
      end
      ST_MEM: begin
        mem_next = prom_read ? prog_data : data_rdata;
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        done_next = 1'b1;
        state_next = ST_FETCH;
        daddr_next = opnd_addr;
        dwdata_next = acc_reg;
        if (alu) begin
          case (func)
            `FN_ADD: acc_next = sum9[7:0];
            `FN_ADC, `FN_SUBTRACT_WITH_CARRY: begin
              acc_next = sum9[7:0];
              c_next = sum9[8];
              hc_next = half5[4];
            end
            `FN_AND: acc_next = acc_reg & opnd;
            `FN_OR: acc_next = acc_reg | opnd;
            `FN_XOR: acc_next = acc_reg ^ opnd;
            `FN_EQ: skip_next = (acc_reg != opnd);
            `FN_NE: skip_next = (acc_reg == opnd);
            `FN_GT: skip_next = !(acc_reg > opnd);
            `FN_LD: acc_next = opnd;
            `FN_XCH: begin
              if (mode != `MODE_IMM) begin
                acc_next = mem_reg;
                dwr_next = 1'b1;
              end
            end
            `FN_LD_INC, `FN_LD_DEC, `FN_XCH_INC, `FN_XCH_DEC: begin
              acc_next = mem_reg;
              dwr_next = (func == `FN_XCH_INC || func == `FN_XCH_DEC);
              if (mode[0])
                x_next = func[0] ? x_reg + 8'h01 : x_reg - 8'h01;
              else
                b_next = func[0] ? b_reg + 8'h01 : b_reg - 8'h01;
            end
            default: ;
          endcase
        end else if (op_reg[7:6] == 2'b00) begin
          if (op_reg[5:0] != `JP_NOP_FIELD)
            pc_next = iaddr_reg + {9'h000, op_reg[5:0]} - `JP_BIAS;
        end else if (op_reg[7:4] == `GRP_LDB_SHORT)
          b_next = {4'h0, op_reg[3:0]};
        else if (op_reg[7:4] == `GRP_NIB_CMP)
          skip_next = (b_reg[3:0] == op_reg[3:0]);
        else if (op_reg[7:3] == `GRP_BIT_SET) begin
          dwdata_next = mem_reg | bit_mask;
          dwr_next = 1'b1;
        end else if (op_reg[7:3] == `GRP_BIT_CLR) begin
          dwdata_next = mem_reg & ~bit_mask;
          dwr_next = 1'b1;
        end else if (op_reg[7:3] == `GRP_BIT_TEST)
          skip_next = ((mem_reg & bit_mask) == 8'h00);
        else if (op_reg[7:4] == `GRP_DEC_SKIP) begin
          dwdata_next = mem_reg - 8'h01;
          dwr_next = 1'b1;
          skip_next = (mem_reg == 8'h01);
        end else if (op_reg[7:4] == `GRP_JMP_ABS)
          pc_next = {pc_reg[14:12], op_reg[3:0], imm1_reg};
        else if (op_reg[7:4] == `GRP_CALL_ABS ||
                 op_reg == `OP_CALL_LONG) begin
          daddr_next = sp_reg;
          dwdata_next = pc_reg[7:0];
          dwr_next = 1'b1;
          done_next = 1'b0;
          state_next = ST_PUSH_HI;
        end else begin
          case (op_reg)
            `OP_JMP_LONG: pc_next = {imm1_reg[6:0], imm2_reg};
            `OP_TBL_LOAD: acc_next = mem_reg;
            `OP_TBL_JUMP: pc_next = {pc_reg[14:8], mem_reg};
            `OP_CLR_PEND: clr_pend = 1'b1;
            `OP_C_SET: begin
              c_next = 1'b1;
              hc_next = 1'b1;
            end
            `OP_C_CLR: begin
              c_next = 1'b0;
              hc_next = 1'b0;
            end
            `OP_ROT_R: begin
              acc_next = {c_reg, acc_reg[7:1]};
              c_next = acc_reg[0];
            end
            `OP_ROT_L: begin
              acc_next = {acc_reg[6:0], c_reg};
              c_next = acc_reg[7];
            end
            `OP_PUSH_A: begin
              daddr_next = sp_reg;
              dwr_next = 1'b1;
              sp_next = sp_reg - 8'h01;
            end
            `OP_POP_A: acc_next = mem_reg;
            `OP_AND_SKIP: skip_next = ((acc_reg & imm1_reg) == 8'h00);
            `OP_MD_EQ: skip_next = (mem_reg != imm2_reg);
            `OP_LDB_IMM: b_next = imm1_reg;
            default: ;
          endcase
        end
      end
      ST_PUSH_HI: begin
        daddr_next = sp_reg - 8'h01;
        dwdata_next = {1'b0, pc_reg[14:8]};
        dwr_next = 1'b1;
        sp_next = sp_reg - 8'h02;
        if (op_reg == `OP_CALL_LONG)
          pc_next = {imm1_reg[6:0], imm2_reg};
        else
          pc_next = {pc_reg[14:12], op_reg[3:0], imm1_reg};
        done_next = 1'b1;
        state_next = ST_FETCH;
      end
      ST_VEC_HI: begin
        imm1_next = prog_data;
        paddr_next = vector_addr + 15'h0001;
        prd_next = 1'b1;
        state_next = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_next = {imm1_reg[6:0], prog_data};
        done_next = 1'b1;
        state_next = ST_FETCH;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_FETCH;
      op_reg <= 8'h00;
      imm1_reg <= 8'h00;
      imm2_reg <= 8'h00;
      mem_reg <= 8'h00;
      skip_reg <= 1'b0;
      iaddr_reg <= `PC_RESET;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      imm1_reg <= imm1_next;
      imm2_reg <= imm2_next;
      mem_reg <= mem_next;
      skip_reg <= skip_next;
      iaddr_reg <= iaddr_next;
      done_reg <= done_next;
    end
  end

  // architectural registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_reg <= `PC_RESET;
      acc_reg <= `ACC_RESET;
      b_reg <= `PTR_RESET;
      x_reg <= `PTR_RESET;
      sp_reg <= `SP_RESET;
      c_reg <= 1'b0;
      hc_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      x_reg <= x_next;
      sp_reg <= sp_next;
      c_reg <= c_next;
      hc_reg <= hc_next;
    end
  end

  // memory port registers
  always_ff @(posedge clk) begin
    if (rst) begin
      paddr_reg <= `PC_RESET;
      prd_reg <= 1'b0;
      daddr_reg <= 8'h00;
      drd_reg <= 1'b0;
      dwr_reg <= 1'b0;
      dwdata_reg <= 8'h00;
    end else begin
      paddr_reg <= paddr_next;
      prd_reg <= prd_next;
      daddr_reg <= daddr_next;
      drd_reg <= drd_next;
      dwr_reg <= dwr_next;
      dwdata_reg <= dwdata_next;
    end
  end

  // soft interrupt pending, a new request wins over the clear
  always_ff @(posedge clk) begin
    if (rst)
      pend_reg <= 1'b0;
    else if (soft_int_set)
      pend_reg <= 1'b1;
    else if (clr_pend)
      pend_reg <= 1'b0;
  end

  assign prog_addr = paddr_reg;
  assign prog_rd = prd_reg;
  assign data_addr = daddr_reg;
  assign data_rd = drd_reg;
  assign data_wr = dwr_reg;
  assign data_wdata = dwdata_reg;
  assign soft_pending = pend_reg;
  assign pc = pc_reg;
  assign acc = acc_reg;
  assign ptr_b = b_reg;
  assign ptr_x = x_reg;
  assign stack_ptr = sp_reg;
  assign carry = c_reg;
  assign half_carry = hc_reg;
  assign instr_done = done_reg;

endmodule // cpu_instruction_semantics

// file: hdl/cpu_defines.svh
`ifndef CPU_DEFINES_SVH
`define CPU_DEFINES_SVH

// widths of the architectural registers
`define PC_W 15
`define PU_W 7
`define DATA_W 8

// reset values
`define PC_RESET 15'h0000
`define ACC_RESET 8'h00
`define PTR_RESET 8'h00
`define SP_RESET 8'h6f

// opcode groups selected by the upper nibble
`define GRP_LDB_SHORT 4'h4
`define GRP_NIB_CMP 4'h5
`define GRP_DEC_SKIP 4'h8
`define GRP_JMP_ABS 4'h9
`define GRP_CALL_ABS 4'ha
// bit operations selected by the upper five bits, low three pick the bit
`define GRP_BIT_SET 5'h0c
`define GRP_BIT_CLR 5'h0d
`define GRP_BIT_TEST 5'h0e

// single opcodes
`define OP_JMP_LONG 8'hb0
`define OP_CALL_LONG 8'hb1
`define OP_TBL_LOAD 8'hb2
`define OP_TBL_JUMP 8'hb3
`define OP_VECTOR 8'hb4
`define OP_CLR_PEND 8'hb5
`define OP_C_SET 8'hb6
`define OP_C_CLR 8'hb7
`define OP_ROT_R 8'hb8
`define OP_ROT_L 8'hb9
`define OP_PUSH_A 8'hba
`define OP_POP_A 8'hbb
`define OP_AND_SKIP 8'hbc
`define OP_MD_EQ 8'hbd
`define OP_LDB_IMM 8'hbe

// arithmetic group 11ffffmm: function and operand mode
`define FN_ADD 4'h0
`define FN_ADC 4'h1
`define FN_SUBTRACT_WITH_CARRY 4'h2
`define FN_AND 4'h3
`define FN_OR 4'h4
`define FN_XOR 4'h5
`define FN_EQ 4'h6
`define FN_NE 4'h7
`define FN_GT 4'h8
`define FN_LD 4'h9
`define FN_XCH 4'ha
`define FN_LD_INC 4'hb
`define FN_LD_DEC 4'hc
`define FN_XCH_INC 4'hd
`define FN_XCH_DEC 4'he
`define MODE_B 2'h0
`define MODE_X 2'h1
`define MODE_DIR 2'h2
`define MODE_IMM 2'h3

// short relative jump: displacement is field minus bias, field 0x20 is +1
`define JP_BIAS 15'h001f
`define JP_NOP_FIELD 6'h20
// register memory page
`define REG_PAGE 4'hf

`endif

// file: hdl/cpu_pkg.sv
package cpu_pkg;

  // instruction sequencer states
  typedef enum logic [3:0] {
    ST_FETCH,
    ST_OP,
    ST_IMM1,
    ST_IMM2,
    ST_ADDR,
    ST_MEM,
    ST_EXEC,
    ST_PUSH_HI,
    ST_VEC_HI,
    ST_VEC_LO
  } seq_state_e;

endpackage

// file: test/mem_model.sv
`timescale 1ns/100ps
`include "cpu_defines.svh"

module mem_model (
  // clock
  input wire logic clk,
  // program side
  input wire logic [`PC_W-1:0] prog_addr,
  input wire logic prog_rd,
  output logic [`DATA_W-1:0] prog_data,
  // data side
  input wire logic [`DATA_W-1:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [`DATA_W-1:0] data_wdata,
  output logic [`DATA_W-1:0] data_rdata
);
  logic [7:0] rom [0:32767];
  logic [7:0] ram [0:255];

  // bytes are valid only while strobed, otherwise inverted garbage
  assign prog_data = prog_rd ? rom[prog_addr] : ~rom[prog_addr];
  assign data_rdata = data_rd ? ram[data_addr] : ~ram[data_addr];

  // store on the edge that ends the write cycle
  always @(posedge clk) begin
    if (data_wr) begin
      ram[data_addr] <= data_wdata;
    end
  end
endmodule // mem_model

// file: test/cpu_checker_assertions.sv
`timescale 1ns/100ps
`include "cpu_defines.svh"

module cpu_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // buses
  input wire logic [`PC_W-1:0] prog_addr,
  input wire logic prog_rd,
  input wire logic [`DATA_W-1:0] prog_data,
  input wire logic [`DATA_W-1:0] data_addr,
  input wire logic data_wr,
  input wire logic [`DATA_W-1:0] data_wdata,
  // state view
  input wire logic soft_int_set,
  input wire logic soft_pending,
  input wire logic [`PC_W-1:0] pc,
  input wire logic [`DATA_W-1:0] acc,
  input wire logic [`DATA_W-1:0] stack_ptr,
  input wire logic carry,
  input wire logic half_carry,
  input wire logic instr_done
);
  logic first_reg;
  logic c_reg;
  logic hc_reg;
  logic [7:0] op_reg;
  logic [7:0] acc_reg;
  logic [7:0] sp_reg;
  logic [`PC_W-1:0] at_reg;
  logic rd1_reg;
  logic rd2_reg;
  logic ran;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // next program read is an opcode after reset or completion
  always_ff @(posedge clk) begin
    if (rst || instr_done) begin
      first_reg <= 1'b1;
    end else if (prog_rd) begin
      first_reg <= 1'b0;
    end
  end

  // snapshot of opcode and state when the opcode is fetched
  always_ff @(posedge clk) begin
    if (!rst && prog_rd && first_reg) begin
      op_reg <= prog_data;
      at_reg <= prog_addr;
      acc_reg <= acc;
      sp_reg <= stack_ptr;
      c_reg <= carry;
      hc_reg <= half_carry;
    end
  end

  // program read history, a skipped instruction ends two cycles after its last byte read
  always_ff @(posedge clk) begin
    rd1_reg <= prog_rd;
    rd2_reg <= rd1_reg;
  end

  // low when the completing instruction was abandoned by a skip or was a table load or table jump
  assign ran = !(rd2_reg && !rd1_reg);

  reset_vals_a: assert property ($fell(rst) |-> pc == 15'h0000
    && acc == 8'h00 && stack_ptr == `SP_RESET && !carry && !soft_pending
    ##[1:3] prog_rd && prog_addr == 15'h0000)
    else $error("bad state after reset");
  pend_set_a: assert property (soft_int_set |=> soft_pending)
    else $error("pending flag not set");
  pend_fall_a: assert property ($fell(soft_pending) |->
    instr_done && op_reg == `OP_CLR_PEND)
    else $error("pending flag cleared by wrong cause");
  carry_set_a: assert property (instr_done && ran
    && op_reg == `OP_C_SET |-> carry && half_carry)
    else $error("carry set wrong");
  rot_right_a: assert property (instr_done && ran
    && op_reg == `OP_ROT_R |-> acc == {c_reg, acc_reg[7:1]}
    && carry == acc_reg[0])
    else $error("rotate right wrong");
  rot_left_a: assert property (instr_done && ran
    && op_reg == `OP_ROT_L |-> acc == {acc_reg[6:0], c_reg}
    && carry == acc_reg[7])
    else $error("rotate left wrong");
  push_write_a: assert property (instr_done && ran
    && op_reg == `OP_PUSH_A |-> data_wr && data_addr == sp_reg
    && data_wdata == acc_reg && stack_ptr == sp_reg - 8'h01)
    else $error("push wrong");
  pop_step_a: assert property (instr_done && ran
    && op_reg == `OP_POP_A |-> stack_ptr == sp_reg + 8'h01)
    else $error("pop stack step wrong");
  short_jump_a: assert property (instr_done && ran
    && op_reg[7:6] == 2'b00 |->
    pc == at_reg + {9'h000, op_reg[5:0]} - `JP_BIAS)
    else $error("short jump target wrong");
  skip_quiet_a: assert property (instr_done && !ran
    && op_reg != `OP_TBL_LOAD && op_reg != `OP_TBL_JUMP |->
    acc == acc_reg && carry == c_reg && half_carry == hc_reg
    && stack_ptr == sp_reg && !data_wr)
    else $error("skipped instruction had an effect");

  // main scenarios
  cover property (instr_done && op_reg == `OP_PUSH_A);
  cover property (instr_done && op_reg == `OP_POP_A);
  cover property ($fell(soft_pending));
  cover property (instr_done && !ran);
endmodule // cpu_checker

bind cpu_instruction_semantics cpu_checker chk (
  .clk(clk),
  .rst(rst),
  .prog_addr(prog_addr),
  .prog_rd(prog_rd),
  .prog_data(prog_data),
  .data_addr(data_addr),
  .data_wr(data_wr),
  .data_wdata(data_wdata),
  .soft_int_set(soft_int_set),
  .soft_pending(soft_pending),
  .pc(pc),
  .acc(acc),
  .stack_ptr(stack_ptr),
  .carry(carry),
  .half_carry(half_carry),
  .instr_done(instr_done)
);

// file: test/tb.sv
`timescale 1ns/100ps
`include "cpu_defines.svh"

module tb;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] b;
    logic [3:0] ch;
  } row_s;
  logic clk, rst, soft_int_set, soft_pending, prog_rd, data_rd, data_wr;
  logic carry, half_carry, instr_done;
  logic [14:0] prog_addr, vector_addr, pc;
  logic [7:0] prog_data, data_addr, data_wdata, data_rdata;
  logic [7:0] acc, ptr_b, ptr_x, stack_ptr;
  logic [15:0] at;
  int n_errors, n_tests;
  row_s rows [29];

  cpu_instruction_semantics uut (.clk(clk), .rst(rst),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata),
    .vector_addr(vector_addr), .soft_int_set(soft_int_set),
    .soft_pending(soft_pending), .pc(pc), .acc(acc), .ptr_b(ptr_b),
    .ptr_x(ptr_x), .stack_ptr(stack_ptr), .carry(carry),
    .half_carry(half_carry), .instr_done(instr_done));
  mem_model pm (.clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd),
    .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task results();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait for n completions, then compare pc and accumulator
  task step(input int n, input logic [15:0] epc, input logic [7:0] eacc);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      @(negedge clk);
      while (instr_done !== 1'b1 && k < 40) begin
        @(negedge clk);
        k++;
      end
      if (k == 40) begin
        n_errors++;
        $display("ERROR %0t: no completion", $time);
        results();
      end
    end
    chk({1'b0, pc}, epc);
    chk({8'h00, acc}, {8'h00, eacc});
  endtask

  task put(input logic [14:0] a, input logic [23:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      pm.rom[a + k[14:0]] = v[23 - 8 * k -: 8];
    end
  endtask

  task reset_chk();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    chk({1'b0, pc}, 16'h0000);
    chk({acc, stack_ptr}, {8'h00, `SP_RESET});
    chk({14'h0, carry, soft_pending}, 16'h0000);
    rst = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    soft_int_set = 1'b0;
    vector_addr = 15'h0200;
    n_errors = 0;
    n_tests = 0;
    for (int i = 0; i < 32768; i++) begin
      pm.rom[i] = 8'hbf;
    end
    foreach (pm.ram[i]) begin
      pm.ram[i] = 8'h00;
    end
    pm.ram[8'h10] = 8'h5a;
    pm.ram[8'hf3] = 8'h01;
    // op, operand, then pc, acc, b and {carry, half carry} afterwards
    rows = '{52'h4f_00_0001_00_0f_0,
      52'hbe_10_0003_00_10_0, 52'he7_3c_0005_3c_10_0,
      52'he6_10_0007_5a_10_0, 52'hb6_00_0008_5a_10_3,
      52'hc7_25_000a_80_10_1, 52'hb7_00_000b_80_10_0,
      52'hcb_01_000d_7e_10_2, 52'hb8_00_000e_bf_10_0,
      52'hb9_00_000f_7e_10_2, 52'hec_00_0010_5a_11_2,
      52'hbc_a5_0012_5a_11_2, 52'he7_ff_0014_5a_11_2,
      52'hdb_5a_0016_5a_11_2, 52'he7_11_0018_11_11_2,
      52'he3_11_001a_11_11_2, 52'he7_22_001c_11_11_2,
      52'h51_00_001d_11_11_2, 52'he7_33_001f_11_11_2,
      52'h83_00_0020_11_11_2, 52'he7_44_0022_11_11_2,
      52'hc3_0f_0024_20_11_2, 52'hd3_05_0026_25_11_2,
      52'hd7_ff_0028_da_11_2, 52'hdf_da_002a_da_11_2,
      52'he7_00_002c_da_11_2, 52'he9_00_002d_00_11_2,
      52'hf5_00_002e_da_11_2, 52'hed_00_002f_00_11_2};
    at = 16'h0000;
    foreach (rows[i]) begin
      put(at[14:0], {rows[i].op, rows[i].arg, 8'h00}, 2);
      at = rows[i].pc;
    end
    // jumps, table reads, vector, bit ops and stack
    put(at[14:0], 24'hb01234, 3);
    put(15'h1234, 24'he780b2, 3);
    put(15'h1237, 24'he740b3, 3);
    put(15'h1250, 24'h932100, 2);
    put(15'h1321, 24'h2000b4, 3);
    put(15'h1303, 24'h3f0000, 1);
    put(15'h0577, 24'h6373e7, 3);
    put(15'h057a, 24'haa6b73, 3);
    put(15'h057d, 24'he7bbba, 3);
    put(15'h0580, 24'he799bb, 3);
    put(15'h0583, 24'hb50000, 1);
    put(15'h1280, 24'h6c0000, 1);
    put(15'h1240, 24'h500000, 1);
    put(15'h0200, 24'h057700, 2);
    // calls, then a memory-to-immediate compare
    put(15'h0586, 24'ha51000, 2);
    put(15'h0510, 24'hb10230, 3);
    put(15'h0230, 24'hbd105a, 3);
    put(15'h0233, 24'he77700, 2);
    @(negedge clk);
    reset_chk();
    foreach (rows[i]) begin
      step(1, rows[i].pc, rows[i].acc);
      chk({8'h00, ptr_b}, {8'h00, rows[i].b});
      chk({14'h0, carry, half_carry}, {12'h0, rows[i].ch});
    end
    chk({8'h00, pm.ram[8'hf3]}, 16'h0000);
    chk({ptr_x, pm.ram[8'h00]}, 16'h0200);
    soft_int_set = 1'b1;
    @(negedge clk);
    soft_int_set = 1'b0;
    step(1, 16'h1234, 8'h00);
    step(2, 16'h1237, 8'h6c);
    step(2, 16'h1250, 8'h40);
    step(1, 16'h1321, 8'h40);
    step(1, 16'h1322, 8'h40);
    step(1, 16'h1303, 8'h40);
    step(1, 16'h1323, 8'h40);
    step(1, 16'h0577, 8'h40);
    step(3, 16'h057b, 8'haa);
    chk({8'h00, pm.ram[8'h11]}, 16'h0008);
    step(3, 16'h057f, 8'haa);
    chk({8'h00, pm.ram[8'h11]}, 16'h0000);
    step(1, 16'h0580, 8'haa);
    chk({8'h00, stack_ptr}, 16'h006e);
    step(2, 16'h0583, 8'haa);
    chk({pm.ram[8'h6f], stack_ptr}, {8'haa, `SP_RESET});
    chk({15'h0, soft_pending}, 16'h0001);
    step(1, 16'h0584, 8'haa);
    chk({14'h0, carry, soft_pending}, 16'h0002);
    step(2, 16'h0586, 8'haa);
    step(1, 16'h0510, 8'haa);
    step(1, 16'h0230, 8'haa);
    step(2, 16'h0235, 8'h77);
    chk({pm.ram[8'h6f], pm.ram[8'h6e]}, 16'h8805);
    chk({pm.ram[8'h6d], pm.ram[8'h6c]}, 16'h1305);
    chk({8'h00, stack_ptr}, 16'h006b);
    reset_chk();
    results();
  end
endmodule // tb
